// *** verilog/utx_state.v ***
// Purpose: per-queue transmit state words and completion pointer of a packet dma
// Assumes: engine strobes come from logic on core_clk; register port never waits
// Notes:   read data appear in the cycle after the read strobe only
//          engine events win over a software write to the same field in one cycle
//          a fetch against an empty buffer is dropped, so the address never runs past it
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "utx_defines.vh"

module utx_state
(
	// clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// descriptor load from the engine
	input  wire        desc_load,
	input  wire [29:0] desc_ptr_in,
	input  wire [31:0] desc_buf_addr,
	input  wire [15:0] desc_buf_len,
	input  wire        desc_is_first,
	input  wire        desc_is_last,
	input  wire [7:0]  desc_tag,
	input  wire [15:0] desc_pkt_len,
	// byte fetch and packet completion from the engine
	input  wire        fetch_byte,
	input  wire        eop_done,
	input  wire [29:0] eop_desc_ptr,
	// state toward the fifo side and trailer generator
	output reg  [31:0] fetch_address,
	output reg  [15:0] fetch_bytes_left,
	output reg  [15:0] trailer_pkt_length,
	output reg  [7:0]  trailer_tag,
	output reg         packet_cut,
	// interrupts
	output reg         queue_irq,
	output reg         irq
);

	// ==========================================================
	// state registers
	reg [29:0] active_desc_pointer_r;
	reg        midpacket_cut_flag_r;
	reg [31:0] active_byte_address_r;
	reg [7:0]  packet_tag_byte_r;
	reg        active_is_last_buffer_r;
	reg        active_is_first_buffer_r;
	reg [15:0] active_bytes_left_r;
	reg [15:0] bytes_before_cut_r;
	reg [15:0] packet_total_r;
	reg [29:0] completed_desc_pointer_r;
	reg        queue_irq_r;
	reg [2:0]  ev_status_r;
	reg [2:0]  ev_enable_r;

	reg [29:0] active_desc_pointer_nxt;
	reg        midpacket_cut_flag_nxt;
	reg [31:0] active_byte_address_nxt;
	reg [7:0]  packet_tag_byte_nxt;
	reg        active_is_last_buffer_nxt;
	reg        active_is_first_buffer_nxt;
	reg [15:0] active_bytes_left_nxt;
	reg [15:0] bytes_before_cut_nxt;
	reg [15:0] packet_total_nxt;
	reg [29:0] completed_desc_pointer_nxt;
	reg        queue_irq_nxt;
	reg [2:0]  ev_enable_nxt;
	reg [31:0] rdata_nxt;
	reg [2:0]  ev_set;
	wire [2:0] ev_status_nxt;
	wire [2:0] ev_masked;

	// ==========================================================
	// address decode
	function sel;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			sel = (addr == ofs);
		end
	endfunction

	wire wr_desc  = reg_wr & sel(reg_addr, `UTX_OFS_CUR_DESC);
	wire wr_addr  = reg_wr & sel(reg_addr, `UTX_OFS_BYTE_ADDR);
	wire wr_info  = reg_wr & sel(reg_addr, `UTX_OFS_BUF_INFO);
	wire wr_len   = reg_wr & sel(reg_addr, `UTX_OFS_PKT_LEN);
	wire wr_comp  = reg_wr & sel(reg_addr, `UTX_OFS_COMPLETION);
	wire wr_clr   = reg_wr & sel(reg_addr, `UTX_OFS_IRQ_CLEAR);
	wire wr_ena   = reg_wr & sel(reg_addr, `UTX_OFS_IRQ_ENABLE);

	wire        wr_action = reg_wdata[`UTX_ACTION_BIT];
	wire [29:0] wr_ptr    = reg_wdata[`UTX_PTR_MSB:`UTX_PTR_LSB];

	// a fetch only counts while the buffer still holds bytes
	wire fetch_ok = fetch_byte & (active_bytes_left_r != `UTX_RST_HALF);

	// ==========================================================
	// fetch stepping
	wire [31:0] byte_address_inc = active_byte_address_r + 32'h0000_0001;
	wire [15:0] bytes_left_dec   = active_bytes_left_r - 16'h0001;
	wire [15:0] before_cut_dec   = bytes_before_cut_r - 16'h0001;
	// the packet runs out while this buffer still has bytes and is not the last
	wire        cut_now          = (bytes_before_cut_r == 16'h0001) & ~active_is_last_buffer_r &
		(active_bytes_left_r != 16'h0001);

	// ==========================================================
	// next-state logic: software first, engine after, so engine events win
	always @*
	begin
		active_desc_pointer_nxt    = active_desc_pointer_r;
		midpacket_cut_flag_nxt     = midpacket_cut_flag_r;
		active_byte_address_nxt    = active_byte_address_r;
		packet_tag_byte_nxt        = packet_tag_byte_r;
		active_is_last_buffer_nxt  = active_is_last_buffer_r;
		active_is_first_buffer_nxt = active_is_first_buffer_r;
		active_bytes_left_nxt      = active_bytes_left_r;
		bytes_before_cut_nxt       = bytes_before_cut_r;
		packet_total_nxt           = packet_total_r;
		ev_enable_nxt              = ev_enable_r;
		ev_set                     = `UTX_RST_EV;

		// software access; reserved bits are simply never stored
		if (wr_desc)
		begin
			active_desc_pointer_nxt = wr_ptr;
			midpacket_cut_flag_nxt  = reg_wdata[`UTX_CUT_BIT];
		end
		if (wr_addr)
			active_byte_address_nxt = reg_wdata;
		if (wr_info)
		begin
			packet_tag_byte_nxt        = reg_wdata[`UTX_TAG_MSB:`UTX_TAG_LSB];
			active_is_last_buffer_nxt  = reg_wdata[`UTX_LAST_BIT];
			active_is_first_buffer_nxt = reg_wdata[`UTX_FIRST_BIT];
			active_bytes_left_nxt      = reg_wdata[`UTX_LO_MSB:0];
		end
		if (wr_len)
		begin
			bytes_before_cut_nxt = reg_wdata[`UTX_PTR_MSB:`UTX_HI_LSB];
			packet_total_nxt     = reg_wdata[`UTX_LO_MSB:0];
		end
		if (wr_ena)
			ev_enable_nxt = reg_wdata[`UTX_EV_W-1:0];

		// engine loads a new buffer descriptor
		if (desc_load)
		begin
			active_desc_pointer_nxt    = desc_ptr_in;
			active_byte_address_nxt    = desc_buf_addr;
			active_bytes_left_nxt      = desc_buf_len;
			active_is_first_buffer_nxt = desc_is_first;
			active_is_last_buffer_nxt  = desc_is_last;
			if (desc_is_first)
			begin
				packet_tag_byte_nxt    = desc_tag;
				packet_total_nxt       = desc_pkt_len;
				bytes_before_cut_nxt   = desc_pkt_len;
				midpacket_cut_flag_nxt = 1'b0;
			end
		end
		else if (fetch_ok)
		begin
			active_byte_address_nxt = byte_address_inc;
			active_bytes_left_nxt   = bytes_left_dec;
			if (active_bytes_left_r == 16'h0001)
				ev_set[`UTX_EV_BUF_EMPTY] = 1'b1;
			if (bytes_before_cut_r != `UTX_RST_HALF)
			begin
				bytes_before_cut_nxt = before_cut_dec;
				if (cut_now)
				begin
					midpacket_cut_flag_nxt = 1'b1;
					ev_set[`UTX_EV_CUT]    = 1'b1;
				end
			end
		end

		if (eop_done)
			ev_set[`UTX_EV_COMPLETE] = 1'b1;
	end

	// ==========================================================
	// completion pointer and queue interrupt
	always @*
	begin
		completed_desc_pointer_nxt = completed_desc_pointer_r;
		queue_irq_nxt              = queue_irq_r;
		if (wr_comp)
		begin
			if (wr_action)
			begin
				completed_desc_pointer_nxt = wr_ptr;
				queue_irq_nxt              = 1'b1;
			end
			else if (wr_ptr == completed_desc_pointer_r)
				queue_irq_nxt = 1'b0;
		end
		// hardware writeback of the finished packet wins over a compare clear
		if (eop_done)
		begin
			completed_desc_pointer_nxt = eop_desc_ptr;
			queue_irq_nxt              = 1'b1;
		end
	end

	// ==========================================================
	// sticky event status: a set in the clearing cycle survives
	genvar ev_i;
	generate
		for (ev_i = 0; ev_i < `UTX_EV_W; ev_i = ev_i + 1)
		begin : g_ev_bit
			wire clr_bit = wr_clr & reg_wdata[ev_i];
			assign ev_status_nxt[ev_i] = (ev_status_r[ev_i] & ~clr_bit) | ev_set[ev_i];
			assign ev_masked[ev_i]     = ev_status_nxt[ev_i] & ev_enable_nxt[ev_i];
		end
	endgenerate

	// ==========================================================
	// read mux
	always @*
	begin
		rdata_nxt = `UTX_RST_WORD;
		case (reg_addr)
			`UTX_OFS_CUR_DESC:
				rdata_nxt = {active_desc_pointer_r, midpacket_cut_flag_r, 1'b0};
			`UTX_OFS_BYTE_ADDR:
				rdata_nxt = active_byte_address_r;
			`UTX_OFS_BUF_INFO:
				rdata_nxt = {packet_tag_byte_r, 6'h00, active_is_last_buffer_r,
					active_is_first_buffer_r, active_bytes_left_r};
			`UTX_OFS_PKT_LEN:
				rdata_nxt = {bytes_before_cut_r, packet_total_r};
			`UTX_OFS_COMPLETION:
				rdata_nxt = {completed_desc_pointer_r, 2'b00};
			`UTX_OFS_IRQ_STATUS:
				rdata_nxt = {29'h0000_0000, ev_status_r};
			`UTX_OFS_IRQ_ENABLE:
				rdata_nxt = {29'h0000_0000, ev_enable_r};
			default:
				rdata_nxt = `UTX_RST_WORD;
		endcase
	end

	// ==========================================================
	// registers
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_desc_pointer_r    <= `UTX_RST_PTR;
			midpacket_cut_flag_r     <= 1'b0;
			active_byte_address_r    <= `UTX_RST_WORD;
			packet_tag_byte_r        <= `UTX_RST_TAG;
			active_is_last_buffer_r  <= 1'b0;
			active_is_first_buffer_r <= 1'b0;
			active_bytes_left_r      <= `UTX_RST_HALF;
			bytes_before_cut_r       <= `UTX_RST_HALF;
			packet_total_r           <= `UTX_RST_HALF;
			completed_desc_pointer_r <= `UTX_RST_PTR;
			queue_irq_r              <= 1'b0;
			ev_status_r              <= `UTX_RST_EV;
			ev_enable_r              <= `UTX_RST_EV;
		end
		else
		begin
			active_desc_pointer_r    <= active_desc_pointer_nxt;
			midpacket_cut_flag_r     <= midpacket_cut_flag_nxt;
			active_byte_address_r    <= active_byte_address_nxt;
			packet_tag_byte_r        <= packet_tag_byte_nxt;
			active_is_last_buffer_r  <= active_is_last_buffer_nxt;
			active_is_first_buffer_r <= active_is_first_buffer_nxt;
			active_bytes_left_r      <= active_bytes_left_nxt;
			bytes_before_cut_r       <= bytes_before_cut_nxt;
			packet_total_r           <= packet_total_nxt;
			completed_desc_pointer_r <= completed_desc_pointer_nxt;
			queue_irq_r              <= queue_irq_nxt;
			ev_status_r              <= ev_status_nxt;
			ev_enable_r              <= ev_enable_nxt;
		end
	end

	// ==========================================================
	// read data
	// read data stand only in the cycle after the strobe
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= `UTX_RST_WORD;
		else
			reg_rdata <= reg_rd ? rdata_nxt : `UTX_RST_WORD;
	end

	// ==========================================================
	// output flops
	// outputs mirror the next state so they match the stored words in the same cycle
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fetch_address      <= `UTX_RST_WORD;
			fetch_bytes_left   <= `UTX_RST_HALF;
			trailer_pkt_length <= `UTX_RST_HALF;
			trailer_tag        <= `UTX_RST_TAG;
			packet_cut         <= 1'b0;
			queue_irq          <= 1'b0;
			irq                <= 1'b0;
		end
		else
		begin
			fetch_address      <= active_byte_address_nxt;
			fetch_bytes_left   <= active_bytes_left_nxt;
			trailer_pkt_length <= packet_total_nxt;
			trailer_tag        <= packet_tag_byte_nxt;
			packet_cut         <= midpacket_cut_flag_nxt;
			queue_irq          <= queue_irq_nxt;
			irq                <= |ev_masked;
		end
	end

endmodule // utx_state

// *** verilog/utx_defines.vh ***
// Purpose: constants for the transmit queue state block
// Assumes: 32-bit register port, word offsets in bytes
// Notes:   offsets of all registers are local to this block
`ifndef UTX_DEFINES_VH
`define UTX_DEFINES_VH

// ==========================================================
// register offsets
`define UTX_OFS_CUR_DESC    8'h00
`define UTX_OFS_BYTE_ADDR   8'h04
`define UTX_OFS_BUF_INFO    8'h08
`define UTX_OFS_PKT_LEN     8'h0C
`define UTX_OFS_COMPLETION  8'h10
`define UTX_OFS_IRQ_STATUS  8'h14
`define UTX_OFS_IRQ_CLEAR   8'h18
`define UTX_OFS_IRQ_ENABLE  8'h1C

// ==========================================================
// field positions
`define UTX_PTR_MSB         31
`define UTX_PTR_LSB         2
`define UTX_CUT_BIT         1
`define UTX_ACTION_BIT      0
`define UTX_TAG_MSB         31
`define UTX_TAG_LSB         24
`define UTX_LAST_BIT        17
`define UTX_FIRST_BIT       16
`define UTX_LO_MSB          15
`define UTX_HI_LSB          16

// ==========================================================
// interrupt status bits
`define UTX_EV_CUT          0
`define UTX_EV_BUF_EMPTY    1
`define UTX_EV_COMPLETE     2
`define UTX_EV_W            3

// ==========================================================
// reset values
`define UTX_RST_WORD        32'h0000_0000
`define UTX_RST_PTR         30'h0000_0000
`define UTX_RST_HALF        16'h0000
`define UTX_RST_TAG         8'h00
`define UTX_RST_EV          3'h0

`endif

// *** bench/utx_state_sva.sv ***
// Purpose: concurrent checks on the transmit queue state ports
// Assumes: one clock core_clk, rst_n asynchronous active low
// Notes:   stored pointers are not ports, so compare clear is checked right after a writeback
`timescale 1ns/1ps
`include "utx_defines.vh"
// ==========================================================
// checker
module utx_state_sva
(
	// clock and reset
	input wire        core_clk,
	input wire        rst_n,
	// register port
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	// engine side
	input wire        desc_load,
	input wire [31:0] desc_buf_addr,
	input wire [15:0] desc_buf_len,
	input wire        desc_is_first,
	input wire [15:0] desc_pkt_len,
	input wire        fetch_byte,
	input wire        eop_done,
	input wire [31:0] fetch_address,
	input wire [15:0] fetch_bytes_left,
	input wire [15:0] trailer_pkt_length,
	input wire        packet_cut,
	input wire        queue_irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire cp_wr = reg_wr && (reg_addr == `UTX_OFS_COMPLETION);
	sequence s_wb;
		cp_wr && reg_wdata[0];
	endsequence
	sequence s_cmp_same;
		cp_wr && !reg_wdata[0] && !eop_done && (reg_wdata[31:2] == $past(reg_wdata[31:2]));
	endsequence
	AST_ACTION_ZERO: assert property (reg_rd && reg_addr == `UTX_OFS_COMPLETION |=> reg_rdata[1:0] == 2'h0)
		else $error("completion low bits not zero");
	AST_WB_IRQ: assert property (s_wb |=> queue_irq)
		else $error("writeback did not raise queue irq");
	AST_CMP_CLR: assert property (s_wb ##0 !eop_done ##1 s_cmp_same |=> !queue_irq)
		else $error("matching compare left queue irq");
	AST_EOP_IRQ: assert property (eop_done |=> queue_irq)
		else $error("finished packet did not raise queue irq");
	AST_LOAD_FIRST: assert property (desc_load && desc_is_first |=> trailer_pkt_length == $past(desc_pkt_len) && !packet_cut)
		else $error("first buffer load wrong");
	AST_LOAD_BUF: assert property (desc_load |=> fetch_address == $past(desc_buf_addr) && fetch_bytes_left == $past(desc_buf_len))
		else $error("buffer load wrong");
	AST_FETCH: assert property (fetch_byte && !desc_load && !reg_wr && fetch_bytes_left != 16'h0000
		|=> fetch_address == $past(fetch_address) + 32'h1 && fetch_bytes_left == $past(fetch_bytes_left) - 16'h1)
		else $error("fetch did not step address and count");
	AST_REFUSE: assert property (fetch_byte && !desc_load && !reg_wr && fetch_bytes_left == 16'h0000 |=> $stable(fetch_address))
		else $error("fetch on empty buffer moved address");
	AST_HOLD: assert property (!fetch_byte && !desc_load && !reg_wr |=> $stable(packet_cut) && $stable(fetch_bytes_left))
		else $error("state moved without cause");
endmodule // utx_state_sva

bind utx_state utx_state_sva utx_state_sva_inst(.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_load(desc_load),
	.desc_buf_addr(desc_buf_addr), .desc_buf_len(desc_buf_len), .desc_is_first(desc_is_first),
	.desc_pkt_len(desc_pkt_len), .fetch_byte(fetch_byte), .eop_done(eop_done), .fetch_address(fetch_address),
	.fetch_bytes_left(fetch_bytes_left), .trailer_pkt_length(trailer_pkt_length), .packet_cut(packet_cut),
	.queue_irq(queue_irq));

// *** bench/utx_engine_model.sv ***
// Purpose: engine side standing in for the fifo feed and descriptor fetch
// Assumes: pulses change by non-blocking assignment just after core_clk rises
// Notes:   unqualified fields are inverted so a stale value never looks valid
`timescale 1ns/1ps
// ==========================================================
// engine model
module utx_engine_model
(
	// clock
	input wire        core_clk,
	// engine strobes and fields
	output reg        desc_load,
	output reg [29:0] desc_ptr_in,
	output reg [31:0] desc_buf_addr,
	output reg [15:0] desc_buf_len,
	output reg        desc_is_first,
	output reg        desc_is_last,
	output reg [7:0]  desc_tag,
	output reg [15:0] desc_pkt_len,
	output reg        fetch_byte,
	output reg        eop_done,
	output reg [29:0] eop_desc_ptr
);
	initial
	begin
		{desc_load, fetch_byte, eop_done, eop_desc_ptr} = 33'h0;
		{desc_ptr_in, desc_buf_addr, desc_buf_len, desc_is_first, desc_is_last, desc_tag, desc_pkt_len} = 104'h0;
	end
	// packet length comes from the third descriptor word
	task load(input [29:0] p, input [31:0] a, input [15:0] n, input fi, input la, input [7:0] t, input [15:0] pl);
	begin
		@(posedge core_clk);
		{desc_load, fetch_byte, eop_done} <= 3'h4;
		{desc_ptr_in, desc_buf_addr, desc_buf_len, desc_is_first, desc_is_last, desc_tag, desc_pkt_len} <= {p, a, n, fi, la, t, pl};
	end
	endtask
	task step(input f, input e, input [29:0] q);
	begin
		@(posedge core_clk);
		{desc_load, fetch_byte, eop_done} <= {1'b0, f, e};
		eop_desc_ptr <= e ? q : ~eop_desc_ptr;
		{desc_ptr_in, desc_buf_addr, desc_buf_len, desc_is_first, desc_is_last, desc_tag, desc_pkt_len} <=
			~{desc_ptr_in, desc_buf_addr, desc_buf_len, desc_is_first, desc_is_last, desc_tag, desc_pkt_len};
	end
	endtask
endmodule // utx_engine_model

// *** bench/tb.sv ***
// Purpose: self-checking bench for the transmit queue state block
// Assumes: reads answer in the cycle after the strobe; outputs settle after the edge
// Notes:   read expectations queue up and a monitor compares them as data arrive
`timescale 1ns/1ps
// ==========================================================
// bench top
module tb;
	reg        core_clk = 1'b0;
	reg        rst_n = 1'b0;
	reg [7:0]  reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0;
	reg        reg_wr = 1'b0;
	reg        reg_rd = 1'b0;
	reg        rd_d = 1'b0;
	reg [31:0] exp_q[$];
	integer    n_fail = 0;
	integer    compares = 0;
	integer    cycles = 0;
	integer    seed;
	reg [31:0] w, a;
	reg [29:0] p, q;
	reg [7:0]  t;
	wire [29:0] desc_ptr_in, eop_desc_ptr;
	wire [31:0] reg_rdata, desc_buf_addr, fetch_address;
	wire [15:0] desc_buf_len, desc_pkt_len, fetch_bytes_left, trailer_pkt_length;
	wire [7:0]  desc_tag, trailer_tag;
	wire        desc_load, desc_is_first, desc_is_last, fetch_byte, eop_done, packet_cut, queue_irq, irq;
	utx_state utx_state_inst(.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_load(desc_load), .desc_ptr_in(desc_ptr_in),
		.desc_buf_addr(desc_buf_addr), .desc_buf_len(desc_buf_len), .desc_is_first(desc_is_first),
		.desc_is_last(desc_is_last), .desc_tag(desc_tag), .desc_pkt_len(desc_pkt_len), .fetch_byte(fetch_byte),
		.eop_done(eop_done), .eop_desc_ptr(eop_desc_ptr), .fetch_address(fetch_address),
		.fetch_bytes_left(fetch_bytes_left), .trailer_pkt_length(trailer_pkt_length), .trailer_tag(trailer_tag),
		.packet_cut(packet_cut), .queue_irq(queue_irq), .irq(irq));
	utx_engine_model utx_engine_model_inst(.core_clk(core_clk), .desc_load(desc_load), .desc_ptr_in(desc_ptr_in),
		.desc_buf_addr(desc_buf_addr), .desc_buf_len(desc_buf_len), .desc_is_first(desc_is_first),
		.desc_is_last(desc_is_last), .desc_tag(desc_tag), .desc_pkt_len(desc_pkt_len), .fetch_byte(fetch_byte),
		.eop_done(eop_done), .eop_desc_ptr(eop_desc_ptr));
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	task check(input [31:0] seen, input [31:0] want);
	begin
		compares = compares + 1;
		if (seen !== want)
		begin
			n_fail = n_fail + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	end
	endtask
	task print_verdict;
	begin
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	task bus(input wr, input rd, input [7:0] ad, input [31:0] d);
	begin
		@(posedge core_clk);
		reg_wr <= wr;
		reg_rd <= rd;
		reg_addr <= ad;
		reg_wdata <= d;
	end
	endtask
	task rd(input [7:0] ad, input [31:0] e);
	begin
		exp_q.push_back(e);
		bus(1'b0, 1'b1, ad, 32'h0);
	end
	endtask
	// idle bus cycle, then look once the edge's updates have landed
	task settle;
	begin
		bus(1'b0, 1'b0, 8'h00, 32'h0);
		#1;
	end
	endtask
	always @(posedge core_clk)
	begin
		if (rd_d)
			check(reg_rdata, exp_q.pop_front());
		rd_d <= reg_rd;
		cycles = cycles + 1;
		if (cycles == 3000)
		begin
			n_fail = n_fail + 1;
			print_verdict;
		end
	end
	initial
	begin
		seed = $urandom(65);
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		check({queue_irq, irq, packet_cut}, 32'h0);
		for (integer i = 0; i <= 32; i = i + 4)
			rd(i[7:0], 32'h0);
		$display("test reset done");
		p = $urandom;
		bus(1'b1, 1'b0, 8'h10, {p, 2'h1});
		bus(1'b1, 1'b0, 8'h10, {~p, 2'h0});
		rd(8'h10, {p, 2'h0});
		settle;
		check(queue_irq, 32'h1);
		bus(1'b1, 1'b0, 8'h10, {p, 2'h0});
		settle;
		check(queue_irq, 32'h0);
		bus(1'b1, 1'b0, 8'h10, {~p, 2'h1});
		bus(1'b1, 1'b0, 8'h10, {~p, 2'h0});
		settle;
		check(queue_irq, 32'h0);
		$display("test completion done");
		w = $urandom;
		for (integer i = 0; i <= 32; i = i + 4)
			bus(1'b1, 1'b0, i[7:0], (i == 24) ? 32'h0 : w);
		rd(8'h00, w & 32'hFFFF_FFFE);
		rd(8'h04, w);
		rd(8'h08, w & 32'hFF03_FFFF);
		rd(8'h0C, w);
		rd(8'h14, 32'h0);
		rd(8'h1C, {29'h0, w[2:0]});
		rd(8'h20, 32'h0);
		settle;
		bus(1'b1, 1'b0, 8'h1C, 32'h0);
		settle;
		$display("test registers done");
		p = $urandom;
		a = $urandom;
		t = $urandom;
		q = $urandom;
		utx_engine_model_inst.load(p, a, 16'h0003, 1'b1, 1'b0, t, 16'h0002);
		utx_engine_model_inst.step(1'b0, 1'b0, 30'h0);
		rd(8'h00, {p, 2'h0});
		rd(8'h08, {t, 6'h0, 2'h1, 16'h0003});
		rd(8'h0C, {16'h0002, 16'h0002});
		rd(8'h04, a);
		settle;
		check(trailer_pkt_length, 32'h2);
		check(trailer_tag, t);
		repeat (4) utx_engine_model_inst.step(1'b1, 1'b0, 30'h0);
		utx_engine_model_inst.step(1'b0, 1'b0, 30'h0);
		#1;
		check(fetch_address, a + 32'h3);
		check({fetch_bytes_left, packet_cut}, 32'h1);
		rd(8'h00, {p, 2'h2});
		rd(8'h14, 32'h3);
		bus(1'b1, 1'b0, 8'h1C, 32'h1);
		settle;
		check(irq, 32'h1);
		bus(1'b1, 1'b0, 8'h1C, 32'h0);
		settle;
		check(irq, 32'h0);
		bus(1'b1, 1'b0, 8'h18, 32'h1);
		rd(8'h14, 32'h2);
		settle;
		utx_engine_model_inst.step(1'b0, 1'b1, q);
		utx_engine_model_inst.step(1'b0, 1'b0, 30'h0);
		#1;
		check(queue_irq, 32'h1);
		rd(8'h10, {q, 2'h0});
		rd(8'h14, 32'h6);
		bus(1'b1, 1'b0, 8'h18, 32'h7);
		rd(8'h14, 32'h0);
		settle;
		$display("test packet done");
		utx_engine_model_inst.load(~p, ~a, 16'h0005, 1'b0, 1'b1, ~t, 16'h0009);
		utx_engine_model_inst.step(1'b0, 1'b0, 30'h0);
		rd(8'h08, {t, 6'h0, 2'h2, 16'h0005});
		settle;
		check(trailer_pkt_length, 32'h2);
		repeat (3) @(posedge core_clk);
		check(exp_q.size(), 32'h0);
		$display("test last buffer done");
		print_verdict;
	end
endmodule // tb
